// ==== sbt_consts.svh ====
// timer constants: register addresses, field positions, fixed ceilings, reset values
// included by the timer design, its checker and its bench
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH
`define SBT_ADDR_CNT_L 4'h0
`define SBT_ADDR_CNT_H 4'h1
`define SBT_ADDR_MA_L 4'h2
`define SBT_ADDR_MA_H 4'h3
`define SBT_ADDR_MB_L 4'h4
`define SBT_ADDR_MB_H 4'h5
`define SBT_ADDR_MC_L 4'h6
`define SBT_ADDR_MC_H 4'h7
`define SBT_ADDR_SN_L 4'h8
`define SBT_ADDR_SN_H 4'h9
`define SBT_ADDR_CTLA 4'ha
`define SBT_ADDR_CTLB 4'hb
`define SBT_ADDR_CTLC 4'hc
`define SBT_ZERO16 16'h0000
`define SBT_ZERO8 8'h00
`define SBT_MAX16 16'hffff
`define SBT_TOP8 16'h00ff
`define SBT_TOP9 16'h01ff
`define SBT_TOP10 16'h03ff
`define SBT_ONE16 16'h0001
`define SBT_FILT_LEN 3'h4
// flag / mask bit positions
`define SBT_BIT_WRAP 0
`define SBT_BIT_MA 1
`define SBT_BIT_MB 2
`define SBT_BIT_MC 3
`define SBT_BIT_SN 5
// control field positions
`define SBT_CS_LSB 0
`define SBT_CS_MSB 2
`define SBT_MODE_LSB 0
`define SBT_MODE_MSB 3
`define SBT_SN_EDGE_BIT 6
`define SBT_SN_FILT_BIT 7
`define SBT_SN_SRC_BIT 5
`endif

// ==== sbt_pkg.sv ====
// timer types: clock select and ceiling source
// no dependencies
package sbt_pkg;
	typedef enum logic [2:0]
	{
		SBT_CS_OFF = 3'b000,
		SBT_CS_INT = 3'b001,
		SBT_CS_D8 = 3'b010,
		SBT_CS_D64 = 3'b011,
		SBT_CS_D256 = 3'b100,
		SBT_CS_D1024 = 3'b101,
		SBT_CS_EXT_FALL = 3'b110,
		SBT_CS_EXT_RISE = 3'b111
	} sbt_cs_t;
	typedef enum logic [2:0]
	{
		SBT_TOP_MAX = 3'b000,
		SBT_TOP_8 = 3'b001,
		SBT_TOP_9 = 3'b010,
		SBT_TOP_10 = 3'b011,
		SBT_TOP_MATCHA = 3'b100,
		SBT_TOP_SNAP = 3'b101
	} sbt_top_t;
endpackage

// ==== sbt_timer.sv ====
// 16-bit timer with three match channels, one snapshot channel and a shared high-byte
// holding register on an 8-bit processor port; prescale strobes come from outside
`timescale 1ns/10ps
`include "sbt_consts.svh"

// Behaviour
// - power gate high keeps timer disabled
// - counter, match, snapshot 16-bit; controls 8-bit free
// - flags in shared flag reg, masked per bit
// - count only on tick; idle without source
// - three match channels, one snapshot channel
// - buffered match values compared continuously, drive pins
// - match sets its channel flag
// - snapshot on chosen edge, optional noise filter
// - ceiling fixed, match A or snapshot
// - match A as PWM ceiling: no output, buffered
// - snapshot ceiling leaves match A for PWM
// - bottom detected at zero
// - all-ones is maximum
// - one holding register shared by all
// - high write only loads holding register
// - low write loads both bytes at once; snapshot only in snapshot ceiling mode
// - low read copies high byte to holding
// - match reads bypass holding register
// - counter high read returns holding register
// - processor counter write beats count/clear
// - snapshot flag set with snapshot copy
module sbt_timer
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic timer_one_power_gate,
	input wire logic [3:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [7:0] busRdata,
	input wire logic prescale8,
	input wire logic prescale64,
	input wire logic prescale256,
	input wire logic prescale1024,
	input wire logic external_tick_pin,
	input wire logic snapshot_input_pin,
	input wire logic comparatorOut,
	input wire logic [5:0] flagClear,
	input wire logic [5:0] timer_irq_mask_reg,
	output logic [5:0] timer_flag_reg,
	output logic [2:0] timerIrq,
	output logic [2:0] match_output_pins,
	output logic atBottom,
	output logic atMax
);
	logic [15:0] count_value;
	logic [15:0] matchA;
	logic [15:0] matchB;
	logic [15:0] matchC;
	logic [15:0] bufA;
	logic [15:0] bufB;
	logic [15:0] bufC;
	logic [15:0] snapshot_value;
	logic [7:0] holdHigh;
	logic [7:0] ctlA;
	logic [7:0] ctlB;
	logic [7:0] ctlC;
	logic extPrev;
	logic timer_tick;
	logic [15:0] ceiling;
	logic atCeiling;
	logic cntWrite;
	logic [2:0] matchHit;
	logic snapIn;
	logic [3:0] filtShift;
	logic filtLevel;
	logic snapPrev;
	logic snapEvent;
	logic snapWrite;
	logic lowWrite;
	logic lowRead;
	sbt_pkg::sbt_cs_t clkSel;
	sbt_pkg::sbt_top_t topSel;
	logic running;

	function automatic logic [15:0] sbt_join(input logic [7:0] hi, input logic [7:0] lo);
		sbt_join = {hi, lo};
	endfunction

	function automatic logic sbt_is_high(input logic [3:0] addr);
		sbt_is_high = addr == `SBT_ADDR_CNT_H || addr == `SBT_ADDR_MA_H
			|| addr == `SBT_ADDR_MB_H || addr == `SBT_ADDR_MC_H || addr == `SBT_ADDR_SN_H;
	endfunction

	assign running = !timer_one_power_gate;
	assign clkSel = sbt_pkg::sbt_cs_t'(ctlB[`SBT_CS_MSB:`SBT_CS_LSB]);
	assign topSel = sbt_pkg::sbt_top_t'(ctlA[`SBT_MODE_LSB+2:`SBT_MODE_LSB]);

	// tick select; external edges seen through a one-stage history
	always_comb
	begin
		unique case (clkSel)
			sbt_pkg::SBT_CS_OFF: timer_tick = 1'b0;
			sbt_pkg::SBT_CS_INT: timer_tick = 1'b1;
			sbt_pkg::SBT_CS_D8: timer_tick = prescale8;
			sbt_pkg::SBT_CS_D64: timer_tick = prescale64;
			sbt_pkg::SBT_CS_D256: timer_tick = prescale256;
			sbt_pkg::SBT_CS_D1024: timer_tick = prescale1024;
			sbt_pkg::SBT_CS_EXT_FALL: timer_tick = extPrev & !external_tick_pin;
			sbt_pkg::SBT_CS_EXT_RISE: timer_tick = !extPrev & external_tick_pin;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			extPrev <= 1'b0;
		else
			extPrev <= external_tick_pin;
	end

	// ceiling source
	always_comb
	begin
		unique case (topSel)
			sbt_pkg::SBT_TOP_8: ceiling = `SBT_TOP8;
			sbt_pkg::SBT_TOP_9: ceiling = `SBT_TOP9;
			sbt_pkg::SBT_TOP_10: ceiling = `SBT_TOP10;
			sbt_pkg::SBT_TOP_MATCHA: ceiling = matchA;
			sbt_pkg::SBT_TOP_SNAP: ceiling = snapshot_value;
			default: ceiling = `SBT_MAX16;
		endcase
	end

	assign atCeiling = (count_value == ceiling);
	assign atBottom = (count_value == `SBT_ZERO16);
	assign atMax = (count_value == `SBT_MAX16);

	assign lowWrite = busWrite & running;
	assign lowRead = busRead & running;
	assign cntWrite = lowWrite && busAddr == `SBT_ADDR_CNT_L;

	// counter: processor write first, then wrap at ceiling, else count
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_value <= `SBT_ZERO16;
		else if (cntWrite)
			count_value <= sbt_join(holdHigh, busWdata);
		else if (running && timer_tick)
		begin
			if (atCeiling)
				count_value <= `SBT_ZERO16;
			else
				count_value <= count_value + `SBT_ONE16;
		end
	end

	// holding register shared by every 16-bit register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			holdHigh <= `SBT_ZERO8;
		else if (lowWrite && sbt_is_high(busAddr))
			holdHigh <= busWdata;
		else if (lowRead && busAddr == `SBT_ADDR_CNT_L)
			holdHigh <= count_value[15:8];
		else if (lowRead && busAddr == `SBT_ADDR_SN_L)
			holdHigh <= snapshot_value[15:8];
	end

	// match value staging; live values reload at the ceiling
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bufA <= `SBT_ZERO16;
			bufB <= `SBT_ZERO16;
			bufC <= `SBT_ZERO16;
		end
		else if (lowWrite)
		begin
			if (busAddr == `SBT_ADDR_MA_L)
				bufA <= sbt_join(holdHigh, busWdata);
			if (busAddr == `SBT_ADDR_MB_L)
				bufB <= sbt_join(holdHigh, busWdata);
			if (busAddr == `SBT_ADDR_MC_L)
				bufC <= sbt_join(holdHigh, busWdata);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			matchA <= `SBT_ZERO16;
			matchB <= `SBT_ZERO16;
			matchC <= `SBT_ZERO16;
		end
		// with the clock off the live copies follow the staged ones at once
		else if (clkSel == sbt_pkg::SBT_CS_OFF || (running && timer_tick && atCeiling))
		begin
			matchA <= bufA;
			matchB <= bufB;
			matchC <= bufC;
		end
	end

	// continuous compare; a processor counter write suppresses that cycle's match
	assign matchHit[0] = running && !cntWrite && count_value == matchA;
	assign matchHit[1] = running && !cntWrite && count_value == matchB;
	assign matchHit[2] = running && !cntWrite && count_value == matchC;

	// simple waveform: toggle on a fresh match tick; A silent when it sets the ceiling
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			match_output_pins <= 3'h0;
		else
		begin
			if (timer_tick && matchHit[0] && topSel != sbt_pkg::SBT_TOP_MATCHA)
				match_output_pins[0] <= !match_output_pins[0];
			if (timer_tick && matchHit[1])
				match_output_pins[1] <= !match_output_pins[1];
			if (timer_tick && matchHit[2])
				match_output_pins[2] <= !match_output_pins[2];
		end
	end

	// snapshot input: source select, noise filter of four equal samples, edge detect
	assign snapIn = ctlB[`SBT_SN_SRC_BIT] ? comparatorOut : snapshot_input_pin;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filtShift <= 4'h0;
			filtLevel <= 1'b0;
			snapPrev <= 1'b0;
		end
		else
		begin
			filtShift <= {filtShift[2:0], snapIn};
			if (!ctlB[`SBT_SN_FILT_BIT])
				filtLevel <= snapIn;
			else if (filtShift == 4'hf || filtShift == 4'h0)
				filtLevel <= filtShift[3];
			snapPrev <= filtLevel;
		end
	end

	assign snapEvent = running && (ctlB[`SBT_SN_EDGE_BIT] ? (filtLevel & !snapPrev)
		: (!filtLevel & snapPrev));
	assign snapWrite = lowWrite && busAddr == `SBT_ADDR_SN_L
		&& topSel == sbt_pkg::SBT_TOP_SNAP;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			snapshot_value <= `SBT_ZERO16;
		else if (snapWrite)
			snapshot_value <= sbt_join(holdHigh, busWdata);
		else if (snapEvent && topSel != sbt_pkg::SBT_TOP_SNAP)
			snapshot_value <= count_value;
	end

	// control registers, plain byte access
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctlA <= `SBT_ZERO8;
			ctlB <= `SBT_ZERO8;
			ctlC <= `SBT_ZERO8;
		end
		else if (lowWrite)
		begin
			if (busAddr == `SBT_ADDR_CTLA)
				ctlA <= busWdata;
			if (busAddr == `SBT_ADDR_CTLB)
				ctlB <= busWdata;
			if (busAddr == `SBT_ADDR_CTLC)
				ctlC <= busWdata;
		end
	end

	// flags: set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_flag_reg <= 6'h00;
		else
		begin
			timer_flag_reg <= timer_flag_reg & ~flagClear;
			if (running && timer_tick && atCeiling)
				timer_flag_reg[`SBT_BIT_WRAP] <= 1'b1;
			if (timer_tick && matchHit[0])
				timer_flag_reg[`SBT_BIT_MA] <= 1'b1;
			if (timer_tick && matchHit[1])
				timer_flag_reg[`SBT_BIT_MB] <= 1'b1;
			if (timer_tick && matchHit[2])
				timer_flag_reg[`SBT_BIT_MC] <= 1'b1;
			if (snapEvent && topSel != sbt_pkg::SBT_TOP_SNAP)
				timer_flag_reg[`SBT_BIT_SN] <= 1'b1;
		end
	end

	assign timerIrq[0] = |(timer_flag_reg[3:0] & timer_irq_mask_reg[3:0]);
	assign timerIrq[1] = timer_flag_reg[`SBT_BIT_SN] & timer_irq_mask_reg[`SBT_BIT_SN];
	// flag bit 4 has no source, so this request stays low
	assign timerIrq[2] = timer_flag_reg[4] & timer_irq_mask_reg[4];

	// read data, registered: answer one cycle after busRead
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			busRdata <= `SBT_ZERO8;
		else if (lowRead)
		begin
			// high reads of count and snapshot see the holding byte
			unique case (busAddr)
				`SBT_ADDR_CNT_L: busRdata <= count_value[7:0];
				`SBT_ADDR_CNT_H: busRdata <= holdHigh;
				`SBT_ADDR_MA_L: busRdata <= bufA[7:0];
				`SBT_ADDR_MA_H: busRdata <= bufA[15:8];
				`SBT_ADDR_MB_L: busRdata <= bufB[7:0];
				`SBT_ADDR_MB_H: busRdata <= bufB[15:8];
				`SBT_ADDR_MC_L: busRdata <= bufC[7:0];
				`SBT_ADDR_MC_H: busRdata <= bufC[15:8];
				`SBT_ADDR_SN_L: busRdata <= snapshot_value[7:0];
				`SBT_ADDR_SN_H: busRdata <= holdHigh;
				`SBT_ADDR_CTLA: busRdata <= ctlA;
				`SBT_ADDR_CTLB: busRdata <= ctlB;
				`SBT_ADDR_CTLC: busRdata <= ctlC;
				default: busRdata <= `SBT_ZERO8;
			endcase
		end
	end
endmodule

// ==== sbt_timer_props.sv ====
// checker on the timer ports: irq masking, holding register, byte writes
// bound into every sbt_timer; sees its ports only
`timescale 1ns/10ps
`include "sbt_consts.svh"
module sbt_timer_props
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic timer_one_power_gate,
	input wire logic [3:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic [7:0] busRdata,
	input wire logic [5:0] timer_irq_mask_reg,
	input wire logic [5:0] timer_flag_reg,
	input wire logic [2:0] timerIrq,
	input wire logic atBottom,
	input wire logic atMax
);
	logic wrOk;
	logic rdOk;
	logic [5:0] fm;
	assign wrOk = busWrite && !timer_one_power_gate;
	assign rdOk = busRead && !busWrite && !timer_one_power_gate;
	assign fm = timer_flag_reg & timer_irq_mask_reg;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	bot_max_a: assert property (!(atBottom && atMax))
		else $error("bottom and max together");
	irq_mask_a: assert property (timerIrq == {fm[4], fm[5], |fm[3:0]})
		else $error("irq not equal to masked flags");
	gate_hold_a: assert property (timer_one_power_gate |=> $stable(busRdata))
		else $error("read data moved while gated");
	rdata_hold_a: assert property (!busRead |=> $stable(busRdata))
		else $error("read data moved without a read");
	hold_share_a: assert property (
		wrOk && busAddr == `SBT_ADDR_MA_H ##1 rdOk && busAddr == `SBT_ADDR_CNT_H
		|=> busRdata == $past(busWdata, 2)) else $error("high read skipped holding");
	cnt_max_a: assert property (
		wrOk && busAddr == `SBT_ADDR_CNT_H && busWdata == 8'hff ##1
		wrOk && busAddr == `SBT_ADDR_CNT_L && busWdata == 8'hff |=> atMax)
		else $error("count write of ffff lost");
	cnt_zero_a: assert property (
		wrOk && busAddr == `SBT_ADDR_CNT_H && busWdata == 8'h00 ##1
		wrOk && busAddr == `SBT_ADDR_CNT_L && busWdata == 8'h00 |=> atBottom)
		else $error("count write of zero lost");
	reset_zero_a: assert property ($rose(rst_n) |-> atBottom && timer_flag_reg == 6'h00)
		else $error("state not clear after reset");
endmodule
bind sbt_timer sbt_timer_props u_props
(
	.sys_clk(sys_clk), .rst_n(rst_n), .timer_one_power_gate(timer_one_power_gate),
	.busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
	.busRdata(busRdata), .timer_irq_mask_reg(timer_irq_mask_reg),
	.timer_flag_reg(timer_flag_reg), .timerIrq(timerIrq), .atBottom(atBottom), .atMax(atMax)
);

// ==== sbt_timer_tb.sv ====
// bench for sbt_timer: byte access, ceilings, match, snapshot, power gate
// drives every input at the falling clock edge; no partner model
`timescale 1ns/10ps
`include "sbt_consts.svh"
module sbt_timer_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, pGate = 1'b0, bWr = 1'b0, bRd = 1'b0, snapPin = 1'b0;
	logic [3:0] bAddr = 4'h0;
	logic [7:0] bWdata = 8'h00, rdata;
	logic [5:0] fClr = 6'h00, mask = 6'h00, flags;
	logic [2:0] div = 3'h0, irq, pins;
	logic bot, mx;
	int failures = 0, compares = 0, n;
	sbt_timer u_dut
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .timer_one_power_gate(pGate), .busAddr(bAddr),
		.busWdata(bWdata), .busWrite(bWr), .busRead(bRd), .busRdata(rdata),
		.prescale8(div == 3'h0), .prescale64(1'b0), .prescale256(1'b0), .prescale1024(1'b0),
		.external_tick_pin(1'b0), .snapshot_input_pin(snapPin), .comparatorOut(1'b0),
		.flagClear(fClr), .timer_irq_mask_reg(mask), .timer_flag_reg(flags), .timerIrq(irq),
		.match_output_pins(pins), .atBottom(bot), .atMax(mx)
	);
	initial forever #4 sys_clk = ~sys_clk;
	always @(negedge sys_clk) div <= div + 3'h1;
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic conclude;
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one byte access; a read is judged against d
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		bWr = w;
		bRd = !w;
		bAddr = a;
		bWdata = d;
		@(negedge sys_clk);
		if (!w)
			chk(rdata === d, "read byte");
	endtask
	task automatic idle;
		bWr = 1'b0;
		bRd = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		acc(1'b1, a + 4'h1, v[15:8]);
		acc(1'b1, a, v[7:0]);
		idle;
	endtask
	task automatic ck16(input logic [3:0] a, input logic [15:0] e);
		acc(1'b0, a, e[7:0]);
		acc(1'b0, a + 4'h1, e[15:8]);
		idle;
	endtask
	task automatic wc(input logic [3:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
		idle;
	endtask
	task automatic clr;
		fClr = 6'h3f;
		@(negedge sys_clk);
		fClr = 6'h00;
	endtask
	task automatic waitf(input int b, input int lim);
		n = 0;
		while (flags[b] !== 1'b1 && n < lim)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(flags[b] === 1'b1, "flag never rose");
		if (flags[b] !== 1'b1)
			conclude;
	endtask
	task automatic t_access;
		for (int i = 0; i < 10; i += 2)
			ck16(i[3:0], 16'h0000);
		wr16(`SBT_ADDR_CNT_L, 16'h1234);
		acc(1'b1, `SBT_ADDR_CNT_H, 8'h56);
		acc(1'b0, `SBT_ADDR_CNT_H, 8'h56);
		ck16(`SBT_ADDR_CNT_L, 16'h1234);
		wr16(`SBT_ADDR_MB_L, 16'h04a5);
		ck16(`SBT_ADDR_MB_L, 16'h04a5);
		wr16(`SBT_ADDR_MA_L, 16'h9abc);
		acc(1'b1, `SBT_ADDR_MA_H, 8'h77);
		acc(1'b0, `SBT_ADDR_CNT_H, 8'h77);
		ck16(`SBT_ADDR_MA_L, 16'h9abc);
		acc(1'b0, `SBT_ADDR_CNT_H, 8'h77);
		idle;
	endtask
	// each ceiling mode: start three below the ceiling, expect a quick wrap
	task automatic t_ceil;
		logic [15:0] top [6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0040, 16'h0080};
		wr16(`SBT_ADDR_MA_L, 16'h0040);
		for (int m = 0; m < 6; m++)
		begin
			wc(`SBT_ADDR_CTLA, m[7:0]);
			if (m == 5)
				wr16(`SBT_ADDR_SN_L, top[5]);
			wr16(`SBT_ADDR_CNT_L, top[m] - 16'h0003);
			clr;
			wc(`SBT_ADDR_CTLB, 8'h01);
			waitf(`SBT_BIT_WRAP, 9);
			wc(`SBT_ADDR_CTLB, 8'h00);
		end
		wc(`SBT_ADDR_CTLA, 8'h00);
		wr16(`SBT_ADDR_SN_L, 16'h1111);
		ck16(`SBT_ADDR_SN_L, 16'h0080);
		wc(`SBT_ADDR_CTLB, 8'h01);
		acc(1'b1, `SBT_ADDR_CNT_H, 8'hff);
		acc(1'b1, `SBT_ADDR_CNT_L, 8'hff);
		chk(mx === 1'b1, "count write lost");
		idle;
		wc(`SBT_ADDR_CTLB, 8'h00);
	endtask
	task automatic t_match;
		logic [2:0] p;
		wr16(`SBT_ADDR_MB_L, 16'h0010);
		wr16(`SBT_ADDR_CNT_L, 16'h0000);
		clr;
		p = pins;
		mask = 6'h04;
		wc(`SBT_ADDR_CTLB, 8'h01);
		waitf(`SBT_BIT_MB, 24);
		chk(n > 10 && pins[1] === ~p[1], "match B time or pin");
		chk(irq[0] === 1'b1, "match irq");
		mask = 6'h00;
		wc(`SBT_ADDR_CTLB, 8'h00);
	endtask
	task automatic t_snap;
		wr16(`SBT_ADDR_CNT_L, 16'h4321);
		wc(`SBT_ADDR_CTLB, 8'h40);
		clr;
		mask = 6'h20;
		snapPin = 1'b1;
		waitf(`SBT_BIT_SN, 6);
		chk(irq[1] === 1'b1, "snapshot irq");
		ck16(`SBT_ADDR_SN_L, 16'h4321);
		snapPin = 1'b0;
		mask = 6'h00;
		wr16(`SBT_ADDR_CNT_L, 16'h0777);
		wc(`SBT_ADDR_CTLB, 8'hc0);
		clr;
		snapPin = 1'b1;
		repeat (2) @(negedge sys_clk);
		snapPin = 1'b0;
		repeat (8) @(negedge sys_clk);
		chk(flags[5] === 1'b0, "filter passed spike");
		snapPin = 1'b1;
		waitf(`SBT_BIT_SN, 12);
		ck16(`SBT_ADDR_SN_L, 16'h0777);
	endtask
	task automatic t_gate;
		clr;
		chk(flags === 6'h00, "flags not cleared");
		pGate = 1'b1;
		wr16(`SBT_ADDR_CNT_L, 16'h5555);
		pGate = 1'b0;
		ck16(`SBT_ADDR_CNT_L, 16'h0777);
	endtask
	initial
	begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		@(negedge sys_clk);
		chk(bot === 1'b1 && flags === 6'h00, "reset outputs");
		t_access;
		t_ceil;
		t_match;
		t_snap;
		t_gate;
		conclude;
	end
endmodule
